// File: inc/speed_ref_pkg.sv
// constants, field layouts and types for the speed reference conditioning block
package speed_ref_pkg;
   // clock and panel timing
   localparam int CLK_KHZ        = 50000;
   localparam int CYC_PER_MS     = CLK_KHZ * 1;
   localparam int LONG_PRESS_MS  = 1000;
   localparam int FLASH_MS       = 1000;
   localparam int LONG_PRESS_CYC = LONG_PRESS_MS * CYC_PER_MS;
   localparam int FLASH_CYC      = FLASH_MS * CYC_PER_MS;
   localparam int TMR_W          = 26;
   // wishbone register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] ACCEL_OFS  = 8'h04;
   localparam logic [7:0] DECEL_OFS  = 8'h08;
   localparam logic [7:0] OFFSET_OFS = 8'h0C;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   // control fields and reset values
   localparam int         CTRL_WP_BIT   = 0;
   localparam int         CTRL_INIT_BIT = 1;
   localparam logic       WP_RST        = 1'b0;
   localparam int         RAMP_W        = 14;
   localparam logic [13:0] RAMP_MAX     = 14'h2710;
   localparam logic [13:0] RAMP_RST     = 14'h0000;
   localparam logic [15:0] OFFSET_RST   = 16'h0000;
   // status fields
   localparam int STAT_SVON_BIT = 16;
   localparam int STAT_PWR_BIT  = 17;
   localparam int STAT_DISP_LSB = 24;
   // full scale speed, in reference units
   localparam logic [29:0] MAX_SPEED = 30'h00007FFF;
   localparam logic signed [15:0] REF_POS_MAX = 16'sh7FFF;
   localparam logic signed [15:0] REF_NEG_MAX = -16'sh7FFF;

   typedef struct packed {
      logic mode_set;
      logic up;
      logic down;
      logic data_shift;
   } keys_t;

   typedef struct packed {
      keys_t keys;
      logic  servo_on;
      logic  motor_power;
   } pins_t;

   typedef enum logic [3:0] {
      DISP_FN_AUTO    = 4'h0,
      DISP_FN_MANUAL  = 4'h1,
      DISP_REF_PROMPT = 4'h2,
      DISP_WAIT_SVON  = 4'h3,
      DISP_MAN_PROMPT = 4'h4,
      DISP_OFFSET     = 4'h5,
      DISP_DONE       = 4'h6,
      DISP_NOOP       = 4'h7
   } disp_code_t;

   typedef struct packed {
      disp_code_t  code;
      logic        flash;
      logic [15:0] value;
   } disp_t;

   typedef enum logic [6:0] {
      ST_MENU     = 7'h01,
      ST_AUTO     = 7'h02,
      ST_MAN_WAIT = 7'h04,
      ST_MAN_PRMT = 7'h08,
      ST_MAN_ADJ  = 7'h10,
      ST_DONE     = 7'h20,
      ST_NOOP     = 7'h40
   } panel_state_t;
endpackage

// File: hw/speed_ref_cond.sv
// speed reference offset calibration, panel sequencing and soft-start ramp
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
// Functional notes
// - auto calibration measures reference offset and corrects it without operator entry
// - measured offset is handed to persistent storage on completion
// - parameter init leaves the stored offset untouched
// - auto refused with not-permitted display if write protected or power on
// - manual entry while write protected flashes not-permitted for one second
// - entering a calibration needs a one second data/shift hold
// - mode/set confirm flashes completion one second then returns to prompt
// - manual up/down keys change the offset live; display shows result
// - soft start turns reference steps into constant-rate ramps
// - acceleration time in ms, 0 to 10000, standstill to maximum speed
// - deceleration time in ms, 0 to 10000, maximum speed to standstill
// - zero ramp times pass the reference straight through
// - real ramp time scales with speed change over maximum speed
module speed_ref_cond import speed_ref_pkg::*; #(
   parameter int LONG_PRESS_CYCLES = LONG_PRESS_CYC,
   parameter int FLASH_CYCLES      = FLASH_CYC,
   parameter int CYCLES_PER_MS     = CYC_PER_MS
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // panel keys and drive status pins
   input  wire pins_t       pins_i,
   // digitised speed reference
   input  wire logic [15:0] vref_i,
   // offset storage
   input  wire logic        nv_load_i,
   input  wire logic [15:0] nv_offset_i,
   output logic             nv_store_o,
   output logic [15:0]      nv_offset_o,
   // panel display and conditioned reference
   output disp_t            disp_o,
   output logic [15:0]      speed_ref_o
);

   // ---------------- pin synchronisers ----------------
   pins_t sync1_q, sync2_q, prev_q;
   keys_t press;

   // two flops per pin, third one only for edge detection
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end else begin
         sync1_q <= pins_i;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   assign press = sync2_q.keys & ~prev_q.keys;

   // ---------------- long press detector ----------------
   logic [TMR_W-1:0] hold_q, hold_d;
   logic             long_press;

   // fires once per hold; key must be released before the next one
   always_comb begin
      hold_d     = hold_q;
      long_press = 1'b0;
      if (!sync2_q.keys.data_shift) begin
         hold_d = '0;
      end else if (hold_q != TMR_W'(LONG_PRESS_CYCLES)) begin
         hold_d = hold_q + 1'b1;
         long_press = (hold_q == TMR_W'(LONG_PRESS_CYCLES - 1));
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_q <= '0;
      end else begin
         hold_q <= hold_d;
      end
   end

   // ---------------- register bus ----------------
   logic              ack_q, ack_d;
   logic [31:0]       rdat_q, rdat_d;
   logic              wp_q, wp_d;
   logic [RAMP_W-1:0] accel_q, accel_d, decel_q, decel_d;
   logic              wr_en;
   logic [15:0]       offset_q;
   disp_t             disp_q;
   logic signed [15:0] out_q;

   function automatic logic [RAMP_W-1:0] ramp_clip(input logic [31:0] v);
      ramp_clip = (v[31:RAMP_W] != '0 || v[RAMP_W-1:0] > RAMP_MAX) ? RAMP_MAX : v[RAMP_W-1:0];
   endfunction

   // single-cycle answer; unmapped offsets read zero and ignore writes
   always_comb begin
      ack_d   = wb_cyc_i & wb_stb_i & ~ack_q;
      wr_en   = ack_d & wb_we_i;
      rdat_d  = '0;
      wp_d    = wp_q;
      accel_d = accel_q;
      decel_d = decel_q;
      case (wb_adr_i)
         CTRL_OFS: begin
            rdat_d[CTRL_WP_BIT] = wp_q;
            if (wr_en && wb_sel_i[0]) begin
               wp_d = wb_dat_i[CTRL_WP_BIT];
               // initialisation clears ramp times, offset is left alone
               if (wb_dat_i[CTRL_INIT_BIT]) begin
                  accel_d = RAMP_RST;
                  decel_d = RAMP_RST;
               end
            end
         end
         ACCEL_OFS: begin
            rdat_d[RAMP_W-1:0] = accel_q;
            if (wr_en && wb_sel_i[1:0] == 2'h3) accel_d = ramp_clip(wb_dat_i);
         end
         DECEL_OFS: begin
            rdat_d[RAMP_W-1:0] = decel_q;
            if (wr_en && wb_sel_i[1:0] == 2'h3) decel_d = ramp_clip(wb_dat_i);
         end
         OFFSET_OFS: rdat_d[15:0] = offset_q;
         STATUS_OFS: begin
            rdat_d[15:0]                = out_q;
            rdat_d[STAT_SVON_BIT]       = sync2_q.servo_on;
            rdat_d[STAT_PWR_BIT]        = sync2_q.motor_power;
            rdat_d[STAT_DISP_LSB +: 4]  = disp_q.code;
         end
         default: rdat_d = '0;
      endcase
      if (!ack_d) rdat_d = '0;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q   <= 1'b0;
         rdat_q  <= '0;
         wp_q    <= WP_RST;
         accel_q <= RAMP_RST;
         decel_q <= RAMP_RST;
      end else begin
         ack_q   <= ack_d;
         rdat_q  <= rdat_d;
         wp_q    <= wp_d;
         accel_q <= accel_d;
         decel_q <= decel_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ---------------- panel sequencer and offset ----------------
   panel_state_t     st_q, st_d;
   logic             sel_man_q, sel_man_d;
   logic             ret_man_q, ret_man_d;
   logic [TMR_W-1:0] tmr_q, tmr_d;
   logic [15:0]      offset_d;
   logic             store_q, store_d;
   disp_t            disp_d;
   logic             permitted;

   // write_protect field at zero means writing is permitted
   assign permitted = ~wp_q;

   always_comb begin
      st_d      = st_q;
      sel_man_d = sel_man_q;
      ret_man_d = ret_man_q;
      tmr_d     = tmr_q;
      offset_d  = offset_q;
      store_d   = 1'b0;
      case (st_q)
         ST_MENU: begin
            if (press.up || press.down) sel_man_d = ~sel_man_q;
            if (long_press) begin
               tmr_d = TMR_W'(FLASH_CYCLES - 1);
               if (!sel_man_q) begin
                  // power or protection wrong: no measurement at all
                  st_d = (permitted && !sync2_q.motor_power) ? ST_AUTO : ST_NOOP;
               end else begin
                  st_d = permitted ? ST_MAN_WAIT : ST_NOOP;
               end
            end
         end
         ST_AUTO: begin
            ret_man_d = 1'b0;
            if (long_press) begin
               st_d = ST_MENU;
            end else if (press.mode_set) begin
               tmr_d = TMR_W'(FLASH_CYCLES - 1);
               if (sync2_q.motor_power || !permitted) begin
                  st_d = ST_NOOP;
               end else begin
                  // 0 V applied, so whatever is read is the offset
                  offset_d = (vref_i == 16'h8000) ? REF_POS_MAX : 16'(-vref_i);
                  store_d  = 1'b1;
                  st_d     = ST_DONE;
               end
            end
         end
         ST_MAN_WAIT: begin
            ret_man_d = 1'b1;
            if (sync2_q.servo_on) st_d = ST_MAN_PRMT;
         end
         ST_MAN_PRMT: begin
            if (long_press) st_d = sync2_q.servo_on ? ST_MAN_ADJ : ST_MENU;
         end
         ST_MAN_ADJ: begin
            // offset is live on the reference as the operator trims it
            if (press.up && $signed(offset_q) != REF_POS_MAX) offset_d = offset_q + 1'b1;
            if (press.down && $signed(offset_q) != REF_NEG_MAX) offset_d = offset_q - 1'b1;
            if (press.mode_set) begin
               store_d = 1'b1;
               tmr_d   = TMR_W'(FLASH_CYCLES - 1);
               st_d    = ST_DONE;
            end
         end
         ST_DONE: begin
            if (tmr_q == '0) st_d = ret_man_q ? ST_MAN_PRMT : ST_AUTO;
            else tmr_d = tmr_q - 1'b1;
         end
         ST_NOOP: begin
            if (tmr_q == '0) st_d = ST_MENU;
            else tmr_d = tmr_q - 1'b1;
         end
         default: st_d = ST_MENU;
      endcase
      // recall from storage whenever in the menu, never while calibrating
      if (nv_load_i && st_q == ST_MENU) offset_d = nv_offset_i;
   end

   // display follows the next state so it changes with the state
   always_comb begin
      disp_d.flash = 1'b0;
      disp_d.value = offset_d;
      case (st_d)
         ST_MENU:     disp_d.code = sel_man_d ? DISP_FN_MANUAL : DISP_FN_AUTO;
         ST_AUTO:     disp_d.code = DISP_REF_PROMPT;
         ST_MAN_WAIT: disp_d.code = DISP_WAIT_SVON;
         ST_MAN_PRMT: disp_d.code = DISP_MAN_PROMPT;
         ST_MAN_ADJ:  disp_d.code = DISP_OFFSET;
         ST_DONE: begin
            disp_d.code  = DISP_DONE;
            disp_d.flash = 1'b1;
         end
         ST_NOOP: begin
            disp_d.code  = DISP_NOOP;
            disp_d.flash = 1'b1;
         end
         default:     disp_d.code = DISP_FN_AUTO;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q      <= ST_MENU;
         sel_man_q <= 1'b0;
         ret_man_q <= 1'b0;
         tmr_q     <= '0;
         offset_q  <= OFFSET_RST;
         store_q   <= 1'b0;
         disp_q    <= '{code: DISP_FN_AUTO, flash: 1'b0, value: OFFSET_RST};
      end else begin
         st_q      <= st_d;
         sel_man_q <= sel_man_d;
         ret_man_q <= ret_man_d;
         tmr_q     <= tmr_d;
         offset_q  <= offset_d;
         store_q   <= store_d;
         disp_q    <= disp_d;
      end
   end

   assign nv_store_o  = store_q;
   assign nv_offset_o = offset_q;
   assign disp_o      = disp_q;

   // ---------------- soft start ramp ----------------
   logic signed [16:0] sum;
   logic signed [15:0] target, out_d;
   logic [29:0]        acc_q, acc_d, acc_sum, thr;
   logic [RAMP_W-1:0]  ramp_t;
   logic               rising, grow;

   // one unit of movement whenever the accumulator passes the ramp
   // threshold; full scale takes exactly ramp_t ms, smaller steps less
   always_comb begin
      sum     = 17'(signed'(vref_i)) + 17'(signed'(offset_q));
      target  = (sum > 17'(REF_POS_MAX)) ? REF_POS_MAX :
                (sum < 17'(REF_NEG_MAX)) ? REF_NEG_MAX : sum[15:0];
      rising  = target > out_q;
      grow    = rising ? (out_q >= 0) : (out_q <= 0);
      ramp_t  = grow ? accel_q : decel_q;
      thr     = 30'(ramp_t) * 30'(CYCLES_PER_MS);
      acc_sum = acc_q + MAX_SPEED;
      out_d   = out_q;
      acc_d   = acc_q;
      if (target == out_q) begin
         acc_d = '0;
      end else if (ramp_t == '0) begin
         out_d = target;
         acc_d = '0;
      end else if (acc_sum >= thr) begin
         acc_d = acc_sum - thr;
         out_d = rising ? out_q + 16'sh0001 : out_q - 16'sh0001;
      end else begin
         acc_d = acc_sum;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= '0;
         out_q <= '0;
      end else begin
         acc_q <= acc_d;
         out_q <= out_d;
      end
   end

   assign speed_ref_o = out_q;

endmodule

// File: dv/speed_ref_checker_assertions.sv
// concurrent checks on the ports of the speed reference conditioning block
`timescale 1ns/1ps
module speed_ref_checker import speed_ref_pkg::*; #(
   parameter int FLASH_CYCLES = FLASH_CYC
) (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst_n,
   // wishbone slave side
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // reference, storage and display
   input wire logic [15:0] vref_i,
   input wire logic        nv_store_o,
   input wire logic [15:0] nv_offset_o,
   input wire disp_t       disp_o
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   logic [25:0] done_cnt_q;
   logic [25:0] done_cnt_d;

   // edges spent flashing completion, judged when the display moves on
   always_comb begin
      done_cnt_d = (disp_o.code == DISP_DONE) ? done_cnt_q + 26'h1 : 26'h0;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_cnt_q <= 26'h0;
      end else begin
         done_cnt_q <= done_cnt_d;
      end
   end

   ack_pulse_a:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held beyond one cycle");
   ack_answer_a:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request left unanswered");
   dat_idle_a:
      assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   store_done_a:
      assert property (nv_store_o |-> disp_o.code == DISP_DONE && disp_o.flash) else $error("store without done");
   auto_meas_a:
      assert property (nv_store_o && $past(disp_o.code) == DISP_REF_PROMPT
         |-> nv_offset_o == (($past(vref_i) == 16'h8000) ? 16'h7FFF : 16'(16'h0 - $past(vref_i))))
         else $error("auto offset wrong");
   done_len_a:
      assert property (disp_o.code != DISP_DONE && done_cnt_q != 26'h0 |-> done_cnt_q == FLASH_CYCLES
         && disp_o.code inside {DISP_REF_PROMPT, DISP_MAN_PROMPT}) else $error("done flash length or exit");
   noop_flash_a:
      assert property (disp_o.code == DISP_NOOP |-> disp_o.flash) else $error("not permitted not flashing");
   noop_exit_a:
      assert property ($fell(disp_o.code == DISP_NOOP)
         |-> disp_o.code inside {DISP_FN_AUTO, DISP_FN_MANUAL}) else $error("refusal left menu");
   adj_step_a:
      assert property (disp_o.code == DISP_OFFSET && $changed(nv_offset_o)
         |-> 16'(nv_offset_o - $past(nv_offset_o)) inside {16'h0001, 16'hFFFF}) else $error("adjust step");
   init_keep_a:
      assert property (wb_ack_o && wb_we_i && wb_adr_i == CTRL_OFS && wb_dat_i[CTRL_INIT_BIT]
         |=> $stable(nv_offset_o)) else $error("init changed offset");
endmodule

bind speed_ref_cond speed_ref_checker #(.FLASH_CYCLES(FLASH_CYCLES)) u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vref_i(vref_i),
   .nv_store_o(nv_store_o), .nv_offset_o(nv_offset_o), .disp_o(disp_o));

// File: dv/panel_host_model.sv
// panel operator and host controller model: keys, servo on, motor power, reference
`timescale 1ns/1ps
module panel_host_model import speed_ref_pkg::*; (
   // clock
   input  wire logic   core_clk,
   // pins and reference towards the drive
   output pins_t       pins_o,
   output logic [15:0] vref_o
);
   // host holds a fixed reference, never a closed position loop
   initial begin
      pins_o = 6'h00;
      vref_o = 16'h0000;
   end

   // press a key for n edges, then leave time for the panel to settle
   task automatic press(input int b, input int n);
      @(posedge core_clk);
      pins_o[b] <= 1'b1;
      repeat (n) @(posedge core_clk);
      pins_o[b] <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask

   // servo on before adjust, power low for auto, main power assumed on
   task automatic set_pin(input int b, input logic v);
      @(posedge core_clk);
      pins_o[b] <= v;
   endtask

   // reference level; the auto run keeps it at the 0 V code plus offset
   task automatic set_ref(input logic [15:0] v);
      @(posedge core_clk);
      vref_o <= v;
   endtask
endmodule

// File: dv/speed_ref_cond_tb.sv
// self-checking bench for the speed reference conditioning block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module speed_ref_cond_tb import speed_ref_pkg::*; ;
   localparam int KMODE = 5;
   localparam int KUP   = 4;
   localparam int KDOWN = 3;
   localparam int KDS   = 2;
   localparam int SVON  = 1;
   localparam int MPWR  = 0;
   logic        core_clk = 1'b0;
   logic        rst_n    = 1'b0;
   logic        wb_cyc   = 1'b0;
   logic        wb_stb   = 1'b0;
   logic        wb_we    = 1'b0;
   logic [7:0]  wb_adr   = 8'h00;
   logic [3:0]  wb_sel   = 4'h0;
   logic [31:0] wb_dat   = 32'h0;
   logic [31:0] wb_rdat;
   logic [31:0] rd;
   logic        wb_ack;
   logic        nv_store;
   logic        nv_load   = 1'b0;
   logic [15:0] nv_offset = 16'h0000;
   logic [3:0]  sel_nx    = 4'hF;
   int          store_cnt = 0;
   pins_t       pins;
   logic [15:0] vref;
   logic [15:0] nv_off;
   logic [15:0] sref;
   disp_t       disp;
   logic [7:0]  ofs [5] = '{CTRL_OFS, ACCEL_OFS, DECEL_OFS, OFFSET_OFS, 8'h14};
   int          error_cnt = 0;
   int          checks    = 0;

   always #10 core_clk = ~core_clk;

   // short counts keep panel holds and flashes within a brief run
   speed_ref_cond #(.LONG_PRESS_CYCLES(20), .FLASH_CYCLES(40), .CYCLES_PER_MS(16)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .pins_i(pins), .vref_i(vref), .nv_load_i(nv_load), .nv_offset_i(nv_offset), .nv_store_o(nv_store),
      .nv_offset_o(nv_off), .disp_o(disp), .speed_ref_o(sref));

   panel_host_model u_ph (.core_clk(core_clk), .pins_o(pins), .vref_o(vref));

   // calibration completions seen on the storage strobe, a one-cycle pulse
   always @(posedge core_clk) begin
      if (nv_store === 1'b1) store_cnt++;
   end

   // recall pulse from storage, one cycle wide, then one edge for the offset to settle
   task automatic nv_recall(input logic [15:0] v);
      @(posedge core_clk);
      nv_load   <= 1'b1;
      nv_offset <= v;
      @(posedge core_clk);
      nv_load   <= 1'b0;
      @(posedge core_clk);
   endtask

   // one classic cycle; held until ack is sampled, then released for an idle cycle
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= a;
      wb_sel <= sel_nx;
      wb_dat <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (n >= 20) error_cnt++;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
      wb(1'b0, a, 32'h0);
      `CHK(nm, ex, rd)
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // cut a hang short well after the expected fifteen hundred or so cycles
   initial begin
      cyc(20000);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      cyc(8);
      rst_n <= 1'b1;
      foreach (ofs[i]) rdchk(ofs[i], 32'h0, "reset_val");
      u_ph.set_ref(16'h1234);
      cyc(3);
      `CHK("pass", 16'h1234, sref)
      // ramp: accel threshold gives one step per two cycles, decel one per cycle
      u_ph.set_ref(16'h0000);
      cyc(3);
      wb(1'b1, ACCEL_OFS, 32'h3000);
      rdchk(ACCEL_OFS, 32'h2710, "accel_clip");
      wb(1'b1, ACCEL_OFS, 32'h1000);
      wb(1'b1, DECEL_OFS, 32'h0800);
      rdchk(DECEL_OFS, 32'h0800, "decel");
      // a write without both low byte lanes is acknowledged but dropped
      sel_nx = 4'h1;
      wb(1'b1, ACCEL_OFS, 32'h0500);
      sel_nx = 4'hF;
      rdchk(ACCEL_OFS, 32'h1000, "accel_sel");
      u_ph.set_ref(16'h0100);
      cyc(256);
      `CHK("accel_mid", 1'b1, sref > 16'h007B && sref < 16'h0085)
      cyc(280);
      `CHK("accel_end", 16'h0100, sref)
      u_ph.set_ref(16'h0000);
      cyc(128);
      `CHK("decel_mid", 1'b1, sref > 16'h007B && sref < 16'h0085)
      cyc(150);
      `CHK("decel_end", 16'h0000, sref)
      u_ph.set_ref(16'h0100);
      cyc(20);
      wb(1'b1, ACCEL_OFS, 32'h0);
      cyc(2);
      `CHK("live_time", 16'h0100, sref)
      wb(1'b1, CTRL_OFS, 32'h2);
      rdchk(DECEL_OFS, 32'h0, "init_decel");
      // auto refused while motor power is on
      u_ph.set_pin(MPWR, 1'b1);
      u_ph.press(KDS, 30);
      `CHK("auto_pwr", DISP_NOOP, disp.code)
      rdchk(STATUS_OFS, 32'h07020100, "status_pwr");
      cyc(50);
      `CHK("noop_back", DISP_FN_AUTO, disp.code)
      u_ph.set_pin(MPWR, 1'b0);
      // auto calibration against a small residual offset
      u_ph.set_ref(16'h0005);
      u_ph.press(KDS, 30);
      `CHK("auto_enter", DISP_REF_PROMPT, disp.code)
      u_ph.press(KMODE, 1);
      `CHK("auto_done", DISP_DONE, disp.code)
      `CHK("auto_ofs", 16'hFFFB, nv_off)
      `CHK("auto_flash", 1'b1, disp.flash)
      `CHK("auto_store", 1, store_cnt)
      cyc(50);
      `CHK("auto_back", DISP_REF_PROMPT, disp.code)
      `CHK("auto_corr", 16'h0000, sref)
      rdchk(STATUS_OFS, 32'h02000000, "status_auto");
      rdchk(OFFSET_OFS, 32'h0000FFFB, "ofs_reg");
      wb(1'b1, CTRL_OFS, 32'h2);
      rdchk(OFFSET_OFS, 32'h0000FFFB, "init_keep");
      u_ph.press(KDS, 30);
      `CHK("auto_exit", DISP_FN_AUTO, disp.code)
      // manual entry refused under write protect
      wb(1'b1, CTRL_OFS, 32'h1);
      u_ph.press(KUP, 1);
      `CHK("sel_man", DISP_FN_MANUAL, disp.code)
      u_ph.press(KDS, 30);
      `CHK("man_wp", DISP_NOOP, disp.code)
      // a recall outside the menu must not disturb the calibrated offset
      nv_recall(16'h1111);
      `CHK("recall_busy", 16'hFFFB, nv_off)
      cyc(50);
      `CHK("man_wp_back", DISP_FN_MANUAL, disp.code)
      wb(1'b1, CTRL_OFS, 32'h0);
      // manual adjust: three up, one down, applied live
      u_ph.press(KDS, 30);
      `CHK("man_wait", DISP_WAIT_SVON, disp.code)
      u_ph.set_pin(SVON, 1'b1);
      cyc(6);
      `CHK("man_prompt", DISP_MAN_PROMPT, disp.code)
      u_ph.press(KDS, 30);
      `CHK("man_adj", DISP_OFFSET, disp.code)
      `CHK("man_show", 16'hFFFB, disp.value)
      repeat (3) u_ph.press(KUP, 1);
      u_ph.press(KDOWN, 1);
      `CHK("man_ofs", 16'hFFFD, nv_off)
      `CHK("man_disp", 16'hFFFD, disp.value)
      `CHK("man_live", 16'h0002, sref)
      rdchk(STATUS_OFS, 32'h05010002, "status_man");
      u_ph.press(KMODE, 1);
      `CHK("man_done", DISP_DONE, disp.code)
      `CHK("man_store", 2, store_cnt)
      cyc(50);
      `CHK("man_back", DISP_MAN_PROMPT, disp.code)
      u_ph.set_pin(SVON, 1'b0);
      u_ph.press(KDS, 30);
      `CHK("man_exit", DISP_FN_MANUAL, disp.code)
      // back in the menu a recall from storage is taken
      nv_recall(16'h0007);
      `CHK("recall_menu", 16'h0007, nv_off)
      `CHK("recall_disp", 16'h0007, disp.value)
      rdchk(OFFSET_OFS, 32'h00000007, "recall_reg");
      report_and_stop();
   end
endmodule
